// >>> rtl/i2c_slave_addr_protocol.sv
`timescale 1ns/1ns
`include "i2c_slave_cfg.svh"

// Behaviour
// - A falling data edge while clock is high starts address reception.
// - Eight bits follow the start: seven address bits MSB first, then read/write.
// - On address match, data is pulled low across the ninth clock pulse.
// - On mismatch, nothing is driven until the next start condition.
// - Every byte is eight data clocks plus one acknowledge clock.
// - Data changes only while clock is low; rising data with clock high stops.
// - The first written byte after the address is taken as a command.
// - A read ends with master not acknowledging, then the master stops.
// - Own address is base 100, first select pin, then second select pin.
// - A quick command is acknowledged and changes no internal state.
// - The address is caught once from the select pins after reset.
// - The slave follows fast-mode clocks up to 400 kHz.
// - A command byte with top bit set marks an extended register write.
module i2c_slave_addr_protocol (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_select_high_pin,
  input wire logic [1:0] addr_select_low_pin,
  input wire logic [7:0] rd_byte,
  output logic rd_take,
  output i2c_slave_pkg::cmd_t cmd,
  output i2c_slave_pkg::wdat_t wdat,
  output logic [6:0] own_addr,
  output logic selected
);

  // ****************************************************************
  // Synchronisers and edge detection
  // ****************************************************************
  logic scl_s1_r;
  logic scl_s2_r;
  logic scl_d_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic sda_d_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
    end
  end

  // Sampling at the reference rate leaves many cycles per fast-mode period.
  localparam int unsigned SCL_MIN_PERIOD = `SCL_MIN_PERIOD_CYC;

  wire scl_high = scl_s2_r & scl_d_r;
  wire start_det = scl_high & sda_d_r & ~sda_s2_r;
  wire stop_det = scl_high & ~sda_d_r & sda_s2_r;
  wire scl_rise = scl_s2_r & ~scl_d_r;
  wire scl_fall = ~scl_s2_r & scl_d_r;

  // ****************************************************************
  // Address capture from the select pins
  // ****************************************************************
  logic [1:0] hi_s1_r;
  logic [1:0] hi_s2_r;
  logic [1:0] lo_s1_r;
  logic [1:0] lo_s2_r;
  logic [1:0] settle_r;
  logic caught_r;
  logic [6:0] own_addr_r;

  wire settle_done = (settle_r == `PIN_SETTLE_CYC);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hi_s1_r <= 2'h0;
      hi_s2_r <= 2'h0;
      lo_s1_r <= 2'h0;
      lo_s2_r <= 2'h0;
    end else begin
      hi_s1_r <= addr_select_high_pin;
      hi_s2_r <= hi_s1_r;
      lo_s1_r <= addr_select_low_pin;
      lo_s2_r <= lo_s1_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      settle_r <= 2'h0;
      caught_r <= 1'b0;
      own_addr_r <= {`ADDR_BASE, 4'h0};
    end else if (!caught_r) begin
      if (settle_done) begin
        caught_r <= 1'b1;
        own_addr_r <= {`ADDR_BASE, hi_s2_r, lo_s2_r};
      end else begin
        settle_r <= settle_r + 2'h1;
      end
    end
  end

  assign own_addr = own_addr_r;

  // ****************************************************************
  // Protocol state machine
  // ****************************************************************
  i2c_slave_pkg::state_t state_r;
  i2c_slave_pkg::state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic oe_r;
  logic oe_nxt;
  logic rw_r;
  logic rw_nxt;
  logic first_r;
  logic first_nxt;
  logic nack_r;
  logic nack_nxt;
  logic take_nxt;
  i2c_slave_pkg::cmd_t cmd_r;
  i2c_slave_pkg::cmd_t cmd_nxt;
  i2c_slave_pkg::wdat_t wdat_r;
  i2c_slave_pkg::wdat_t wdat_nxt;

  wire byte_full = (cnt_r == `BIT_CNT_FULL);
  wire shift_in = scl_rise & ~byte_full;
  wire [7:0] sh_in = {sh_r[6:0], sda_s2_r};
  wire [3:0] cnt_inc = cnt_r + `BIT_CNT_ONE;
  wire addr_match = caught_r & (sh_r[7:1] == own_addr_r);
  // The first read bit goes out as soon as the byte is loaded.
  wire rd_msb_drive = ~rd_byte[`MSB_BIT];

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    oe_nxt = oe_r;
    rw_nxt = rw_r;
    first_nxt = first_r;
    nack_nxt = nack_r;
    take_nxt = 1'b0;
    cmd_nxt = cmd_r;
    cmd_nxt.valid = 1'b0;
    wdat_nxt = wdat_r;
    wdat_nxt.valid = 1'b0;
    if (start_det) begin
      state_nxt = i2c_slave_pkg::ST_ADDR;
      cnt_nxt = `BIT_CNT_ZERO;
      oe_nxt = 1'b0;
    end else if (stop_det) begin
      state_nxt = i2c_slave_pkg::ST_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (state_r)
        i2c_slave_pkg::ST_IDLE: begin
          oe_nxt = 1'b0;
        end
        i2c_slave_pkg::ST_ADDR: begin
          if (shift_in) begin
            sh_nxt = sh_in;
            cnt_nxt = cnt_inc;
          end else if (scl_fall && byte_full) begin
            if (addr_match) begin
              state_nxt = i2c_slave_pkg::ST_ADDR_ACK;
              oe_nxt = 1'b1;
              rw_nxt = (sh_r[0] == `RW_READ);
              first_nxt = 1'b1;
            end else begin
              state_nxt = i2c_slave_pkg::ST_IDLE;
            end
          end
        end
        i2c_slave_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_nxt = `BIT_CNT_ZERO;
            if (rw_r) begin
              state_nxt = i2c_slave_pkg::ST_RD_BYTE;
              sh_nxt = rd_byte;
              oe_nxt = rd_msb_drive;
              take_nxt = 1'b1;
            end else begin
              state_nxt = i2c_slave_pkg::ST_WR_BYTE;
              oe_nxt = 1'b0;
            end
          end
        end
        i2c_slave_pkg::ST_WR_BYTE: begin
          if (shift_in) begin
            sh_nxt = sh_in;
            cnt_nxt = cnt_inc;
          end else if (scl_fall && byte_full) begin
            state_nxt = i2c_slave_pkg::ST_WR_ACK;
            oe_nxt = 1'b1;
            if (first_r) begin
              first_nxt = 1'b0;
              cmd_nxt.valid = 1'b1;
              cmd_nxt.ext = sh_r[`CMD_EXT_BIT];
              cmd_nxt.code = sh_r[6:0];
            end else begin
              wdat_nxt.valid = 1'b1;
              wdat_nxt.data = sh_r;
            end
          end
        end
        i2c_slave_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            state_nxt = i2c_slave_pkg::ST_WR_BYTE;
            cnt_nxt = `BIT_CNT_ZERO;
            oe_nxt = 1'b0;
          end
        end
        i2c_slave_pkg::ST_RD_BYTE: begin
          if (scl_rise) begin
            cnt_nxt = cnt_inc;
          end else if (scl_fall) begin
            if (byte_full) begin
              state_nxt = i2c_slave_pkg::ST_RD_ACK;
              oe_nxt = 1'b0;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_nxt = ~sh_r[`NEXT_MSB_BIT];
            end
          end
        end
        i2c_slave_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            nack_nxt = sda_s2_r;
          end else if (scl_fall) begin
            cnt_nxt = `BIT_CNT_ZERO;
            if (nack_r) begin
              state_nxt = i2c_slave_pkg::ST_IDLE;
            end else begin
              state_nxt = i2c_slave_pkg::ST_RD_BYTE;
              sh_nxt = rd_byte;
              oe_nxt = rd_msb_drive;
              take_nxt = 1'b1;
            end
          end
        end
        default: begin
          state_nxt = i2c_slave_pkg::ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= i2c_slave_pkg::ST_IDLE;
      cnt_r <= `BIT_CNT_ZERO;
      sh_r <= 8'h00;
      oe_r <= 1'b0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      nack_r <= 1'b0;
      rd_take <= 1'b0;
      cmd_r <= '0;
      wdat_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      oe_r <= oe_nxt;
      rw_r <= rw_nxt;
      first_r <= first_nxt;
      nack_r <= nack_nxt;
      rd_take <= take_nxt;
      cmd_r <= cmd_nxt;
      wdat_r <= wdat_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sda_out = 1'b0;
  assign sda_oe = oe_r;
  assign cmd = cmd_r;
  assign wdat = wdat_r;
  assign selected = (state_r != i2c_slave_pkg::ST_IDLE) && (state_r != i2c_slave_pkg::ST_ADDR);

endmodule

// >>> rtl/i2c_slave_cfg.svh
`ifndef I2C_SLAVE_CFG_SVH
`define I2C_SLAVE_CFG_SVH

// ****************************************************************
// Address composition
// ****************************************************************
`define ADDR_BASE 3'h4
`define RW_READ 1'h1

// ****************************************************************
// Byte framing
// ****************************************************************
`define BIT_CNT_ZERO 4'h0
`define BIT_CNT_ONE 4'h1
`define BIT_CNT_FULL 4'h8
`define CMD_EXT_BIT 7
`define MSB_BIT 7
`define NEXT_MSB_BIT 6

// ****************************************************************
// Timing
// ****************************************************************
`define REF_CLK_MHZ 100
`define SCL_MAX_KHZ 400
`define SCL_MIN_PERIOD_CYC ((`REF_CLK_MHZ * 1000) / `SCL_MAX_KHZ)
`define PIN_SETTLE_CYC 2'h3

`endif

// >>> rtl/i2c_slave_pkg.sv
package i2c_slave_pkg;

  // ****************************************************************
  // Protocol states
  // ****************************************************************
  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WR_BYTE  = 7'h08,
    ST_WR_ACK   = 7'h10,
    ST_RD_BYTE  = 7'h20,
    ST_RD_ACK   = 7'h40
  } state_t;

  // ****************************************************************
  // User-side carriers
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic ext;
    logic [6:0] code;
  } cmd_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } wdat_t;

endpackage

// >>> verif/i2c_slave_addr_protocol_checker.sv
`timescale 1ns/1ns
// ****
// Port checks.
// ****
module i2c_slave_addr_protocol_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [1:0] addr_select_high_pin,
  input wire logic [1:0] addr_select_low_pin,
  input wire logic rd_take,
  input wire i2c_slave_pkg::cmd_t cmd,
  input wire i2c_slave_pkg::wdat_t wdat,
  input wire logic [6:0] own_addr,
  input wire logic selected
);
  logic [3:0] up_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      up_r <= 4'h0;
    end else if (up_r != 4'hF) begin
      up_r <= up_r + 4'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_BASE: assert property (own_addr[6:4] == 3'h4)
    else $error("Address base wrong.");
  AST_CAPTURE: assert property (up_r == 4'hF |->
    own_addr == {3'h4, addr_select_high_pin, addr_select_low_pin})
    else $error("Address not captured.");
  AST_OE_SEL: assert property (sda_oe |-> selected)
    else $error("Drive while not selected.");
  AST_OE_EDGE: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("Drive changed with clock high.");
  AST_OE_HOLD: assert property (sda_oe && $rose(scl_in) |-> sda_oe[*5])
    else $error("Drive dropped in clock high.");
  AST_OUT_LOW: assert property (sda_out == 1'b0)
    else $error("Data output not low.");
  AST_CMD_ACK: assert property (cmd.valid |-> $rose(sda_oe) ##1 !cmd.valid)
    else $error("Command pulse wrong.");
  AST_WDAT_ACK: assert property (wdat.valid |-> $rose(sda_oe) && selected ##1 !wdat.valid)
    else $error("Write data pulse wrong.");
  AST_RD_TAKE: assert property (rd_take |-> selected ##1 !rd_take)
    else $error("Read load pulse wrong.");
  cover property (cmd.valid && cmd.ext);
  cover property (wdat.valid);
  cover property (rd_take);
endmodule
bind i2c_slave_addr_protocol i2c_slave_addr_protocol_checker u_chk (
  .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .addr_select_high_pin(addr_select_high_pin), .addr_select_low_pin(addr_select_low_pin),
  .rd_take(rd_take), .cmd(cmd), .wdat(wdat), .own_addr(own_addr), .selected(selected));

// >>> verif/i2c_bus_master_model.sv
`timescale 1ns/1ns
// ****
// Bus master.
// ****
module i2c_bus_master_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data is released with the clock low before a repeated start.
  task automatic start();
    #31 sda_low <= 1'b0;
    #32 scl <= 1'b1;
    #31 sda_low <= 1'b1;
    #31 scl <= 1'b0;
  endtask
  task automatic clk_bit(input logic b, output logic r);
    #31 sda_low <= ~b;
    #32 scl <= 1'b1;
    #31 r = sda;
    #31 scl <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, ack);
  endtask
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(ack, r);
  endtask
  // The bus stays free after the stop so the slave can see it.
  task automatic stop();
    #31 sda_low <= 1'b1;
    #32 scl <= 1'b1;
    #62 sda_low <= 1'b0;
    #63;
  endtask
endmodule

// >>> verif/i2c_slave_addr_protocol_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module i2c_slave_addr_protocol_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, m_low, sda_oe, sda_out, rd_take, selected, ack, r;
  wire logic sda = !(m_low || (sda_oe && !sda_out));
  logic [1:0] hi_pin = 2'h0;
  logic [1:0] lo_pin = 2'h0;
  logic [7:0] rd_byte = 8'h00;
  logic [7:0] got;
  logic [6:0] own_addr;
  i2c_slave_pkg::cmd_t cmd;
  i2c_slave_pkg::wdat_t wdat;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int ncmd = 0;
  int noe = 0;
  int nrd = 0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cmd.valid === 1'b1) ncmd++;
    if (sda_oe === 1'b1) noe++;
    if (rd_take === 1'b1) nrd++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  i2c_bus_master_model u_mst (.scl(scl), .sda_low(m_low), .sda(sda));
  i2c_slave_addr_protocol u_dut (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_high_pin(hi_pin),
    .addr_select_low_pin(lo_pin), .rd_byte(rd_byte), .rd_take(rd_take), .cmd(cmd),
    .wdat(wdat), .own_addr(own_addr), .selected(selected));
  task automatic complete_run();
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] h, input logic [1:0] l);
    @(negedge ref_clk);
    rst = 1'b1;
    hi_pin = h;
    lo_pin = l;
    repeat (16) @(negedge ref_clk);
    `CHK(own_addr, 7'h40)
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic quick(input logic [6:0] a, input logic exp);
    int n;
    n = ncmd;
    u_mst.start();
    u_mst.send({a, 1'b0}, ack);
    u_mst.stop();
    `CHK(ack, exp)
    `CHK(ncmd, n)
  endtask
  task automatic t_addr();
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1:0], 2'(i + 1));
      `CHK(own_addr, {3'h4, i[1:0], 2'(i + 1)})
      quick({3'h4, i[1:0], 2'(i + 1)}, 1'b0);
    end
    do_reset(2'h3, 2'h0);
  endtask
  task automatic t_miss();
    int n;
    n = noe;
    quick(7'h4D, 1'b1);
    `CHK(noe, n)
  endtask
  task automatic t_write(input logic [7:0] c);
    int n;
    n = ncmd;
    u_mst.start();
    u_mst.send({7'h4C, 1'b0}, ack);
    u_mst.send(c, ack);
    `CHK(ack, 1'b0)
    u_mst.send(~c, ack);
    u_mst.stop();
    `CHK(ncmd, n + 1)
    `CHK(cmd.ext, c[7])
    `CHK(cmd.code, c[6:0])
    `CHK(wdat.data, ~c)
    `CHK(selected, 1'b0)
  endtask
  task automatic t_read();
    int n;
    n = nrd;
    @(negedge ref_clk);
    rd_byte = 8'hA5;
    u_mst.start();
    u_mst.send({7'h4C, 1'b1}, ack);
    fork
      u_mst.recv(1'b0, got);
      begin
        @(posedge rd_take);
        @(negedge ref_clk);
        rd_byte = 8'h5A;
      end
    join
    `CHK(got, 8'hA5)
    u_mst.recv(1'b1, got);
    `CHK(got, 8'h5A)
    `CHK(sda_oe, 1'b0)
    u_mst.stop();
    `CHK(nrd, n + 2)
    `CHK(selected, 1'b0)
  endtask
  task automatic t_abort();
    int n;
    n = ncmd;
    u_mst.start();
    u_mst.send({7'h4C, 1'b0}, ack);
    repeat (3) u_mst.clk_bit(1'b1, r);
    u_mst.stop();
    `CHK(selected, 1'b0)
    u_mst.start();
    u_mst.send({7'h4C, 1'b0}, ack);
    repeat (4) u_mst.clk_bit(1'b0, r);
    u_mst.start();
    u_mst.send({7'h4C, 1'b0}, ack);
    u_mst.stop();
    `CHK(ack, 1'b0)
    `CHK(ncmd, n)
  endtask
  initial begin
    t_addr();
    t_miss();
    t_write(8'h85);
    t_write(8'h12);
    t_read();
    t_abort();
    complete_run();
  end
endmodule
